// ---- shared/refclk_defines.vh ----
// Purpose: Offsets, field positions and reset values of the clock-control block.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef REFCLK_DEFINES_VH
`define REFCLK_DEFINES_VH
`define OFF_OSC_CTRL      4'h0
`define OFF_RC_TUNE       4'h4
`define OFF_REF_CTRL      4'h8
`define OFF_REF_TRIM      4'hc
`define OFF_UNLOCK        4'h0
`define UNLOCK_WORD_A     32'haa996655
`define UNLOCK_WORD_B     32'h556699aa
`define OSC_SWITCH_BIT    0
`define OSC_SOSC_BIT      1
`define OSC_USBRC_BIT     2
`define OSC_FAIL_BIT      3
`define OSC_NEWSRC_LO     8
`define REF_DIV_LO        16
`define REF_ON_BIT        15
`define REF_STOP_IN_IDLE_BIT      13
`define REF_OE_BIT        12
`define REF_RUN_IN_SLEEP_BIT      11
`define REF_SWITCH_BIT    9
`define REF_ACTIVE_BIT    8
`define TRIM_LO           23
`define NEWSRC_RESET      3'h0
`define OSC_SWITCH_CYCLES 4'h8
`endif

// ---- src/reference_clock_and_osc_tune.v ----
// Purpose: Oscillator control, fast RC tuning and reference clock generator.
// Assumes: All inputs synchronous to clk; sources arrive as sampled levels.
// Notes:   Oscillator control and RC tuning are written only after the two-word unlock sequence; reference control and trim need no unlock.
`include "refclk_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module reference_clock_and_osc_tune
#(
  parameter DIV_W  = 15,
  parameter TRIM_W = 9
)
(
  input  wire        clk,
  input  wire        rst,
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  input  wire        failSafeMonitor,
  input  wire        idleMode,
  input  wire        sleepMode,
  input  wire [8:0]  sourceClocks,
  output reg         refClockOutPin,
  output reg         refClockOutEn,
  output reg         usbRcSourceSelect,
  output reg         secondaryOscEnable,
  output reg  [2:0]  activeSource,
  output reg  [5:0]  rcTuneValue
);
  // ----------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------
  reg              clockFailFlag_q;
  reg              clockSwitchRequest_q;
  reg  [2:0]       newSourceField_q;
  reg  [3:0]       switchCount_q;
  reg  [1:0]       unlockState_q;
  reg              refOn_q;
  reg              stopInIdle_q;
  reg              outEnable_q;
  reg              runInSleep_q;
  reg              dividerSwitch_q;
  reg  [3:0]       selPend_q;
  reg  [DIV_W-1:0] divPend_q;
  reg  [TRIM_W-1:0] trimPend_q;
  reg  [3:0]       selAct_q;
  reg  [DIV_W-1:0] divAct_q;
  reg  [TRIM_W-1:0] trimAct_q;
  reg              accessDone_q;
  reg  [DIV_W+TRIM_W:0] phaseCount_q;
  reg              trimAcc_q;
  reg  [TRIM_W-1:0] fracAcc_q;
  reg              refClk_q;
  reg              srcPrev_q;

  wire unlocked = (unlockState_q == 2'h2);
  wire wrStrobe = write & ~waitrequest;
  wire rdStrobe = read & ~accessDone_q;
  wire wrOsc  = wrStrobe & unlocked & (address == `OFF_OSC_CTRL);
  wire wrTune = wrStrobe & unlocked & (address == `OFF_RC_TUNE);
  wire wrRef  = wrStrobe & (address == `OFF_REF_CTRL);
  wire wrTrim = wrStrobe & (address == `OFF_REF_TRIM);

  // ----------------------------------------------------------------
  // Reference run conditions and source edge detection.
  // ----------------------------------------------------------------
  wire sleepIgnored = (selAct_q == 4'h0) | (selAct_q == 4'h1);
  wire runGen = refOn_q
              & ~(stopInIdle_q & idleMode)
              & ~(sleepMode & ~runInSleep_q & ~sleepIgnored);
  wire srcValid = (selAct_q <= 4'h8);
  wire srcLevel = srcValid ? sourceClocks[selAct_q] : 1'b0;
  wire srcEdge = srcLevel & ~srcPrev_q;
  wire [DIV_W+TRIM_W:0] halfPeriod = {1'b0, divAct_q, {TRIM_W{1'b0}}};
  wire [TRIM_W:0] fracSum = {1'b0, fracAcc_q} + {1'b0, trimAct_q};
  wire halfDone = (phaseCount_q + {{DIV_W{1'b0}}, 1'b1, {TRIM_W{1'b0}}}) >=
                  (halfPeriod + {{(DIV_W+1){1'b0}}, trimAcc_q & fracSum[TRIM_W],
                   {(TRIM_W-1){1'b0}}});
  wire atBoundary = ~refClk_q & (~srcEdge | halfDone);

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle per access, unlock sequencing.
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      accessDone_q <= 1'b0;
      waitrequest  <= 1'b1;
      readdata     <= 32'h00000000;
      unlockState_q <= 2'h0;
    end
    else
    begin
      accessDone_q <= (read | write) & ~accessDone_q;
      waitrequest  <= ~((read | write) & ~accessDone_q);
      if (rdStrobe)
      begin
        case (address)
          `OFF_OSC_CTRL: readdata <= {21'h0, newSourceField_q, 4'h0, clockFailFlag_q,
                                      usbRcSourceSelect, secondaryOscEnable,
                                      clockSwitchRequest_q};
          `OFF_RC_TUNE:  readdata <= {26'h0, rcTuneValue};
          `OFF_REF_CTRL: readdata <= {1'b0, divPend_q, refOn_q, 1'b0, stopInIdle_q,
                                      outEnable_q, runInSleep_q, 1'b0, dividerSwitch_q,
                                      runGen, 4'h0, selPend_q};
          `OFF_REF_TRIM: readdata <= {trimPend_q, 23'h0};
          default:       readdata <= 32'h00000000;
        endcase
      end
      if (wrStrobe)
      begin
        if (address == `OFF_UNLOCK && writedata == `UNLOCK_WORD_A)
          unlockState_q <= 2'h1;
        else if (address == `OFF_UNLOCK && writedata == `UNLOCK_WORD_B
                 && unlockState_q == 2'h1)
          unlockState_q <= 2'h2;
        else
          unlockState_q <= 2'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator control and fast RC tuning.
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      clockFailFlag_q      <= 1'b0;
      clockSwitchRequest_q <= 1'b0;
      newSourceField_q     <= `NEWSRC_RESET;
      switchCount_q        <= 4'h0;
      usbRcSourceSelect    <= 1'b0;
      secondaryOscEnable   <= 1'b0;
      activeSource         <= `NEWSRC_RESET;
      rcTuneValue          <= 6'h00;
    end
    else
    begin
      if (failSafeMonitor)
        clockFailFlag_q <= 1'b1;
      else if (wrOsc && !writedata[`OSC_FAIL_BIT])
        clockFailFlag_q <= 1'b0;
      if (wrOsc)
      begin
        usbRcSourceSelect  <= writedata[`OSC_USBRC_BIT];
        secondaryOscEnable <= writedata[`OSC_SOSC_BIT];
        newSourceField_q   <= writedata[`OSC_NEWSRC_LO+2:`OSC_NEWSRC_LO];
      end
      if (wrOsc && writedata[`OSC_SWITCH_BIT] && !clockSwitchRequest_q)
      begin
        clockSwitchRequest_q <= 1'b1;
        switchCount_q        <= `OSC_SWITCH_CYCLES;
      end
      else if (clockSwitchRequest_q)
      begin
        if (switchCount_q == 4'h1)
        begin
          activeSource         <= newSourceField_q;
          clockSwitchRequest_q <= 1'b0;
        end
        switchCount_q <= switchCount_q - 4'h1;
      end
      if (wrTune)
        rcTuneValue <= writedata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Reference control, trim and divider switch handshake.
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      refOn_q         <= 1'b0;
      stopInIdle_q    <= 1'b0;
      outEnable_q     <= 1'b0;
      runInSleep_q    <= 1'b0;
      dividerSwitch_q <= 1'b0;
      selPend_q       <= 4'h0;
      divPend_q       <= {DIV_W{1'b0}};
      trimPend_q      <= {TRIM_W{1'b0}};
      selAct_q        <= 4'h0;
      divAct_q        <= {DIV_W{1'b0}};
      trimAct_q       <= {TRIM_W{1'b0}};
    end
    else
    begin
      if (wrRef)
      begin
        refOn_q      <= writedata[`REF_ON_BIT];
        stopInIdle_q <= writedata[`REF_STOP_IN_IDLE_BIT];
        outEnable_q  <= writedata[`REF_OE_BIT];
        runInSleep_q <= writedata[`REF_RUN_IN_SLEEP_BIT];
        selPend_q    <= writedata[3:0];
        divPend_q    <= writedata[`REF_DIV_LO+DIV_W-1:`REF_DIV_LO];
        if (writedata[`REF_SWITCH_BIT])
          dividerSwitch_q <= 1'b1;
      end
      if (wrTrim)
        trimPend_q <= writedata[`TRIM_LO+TRIM_W-1:`TRIM_LO];
      if (!refOn_q)
      begin
        selAct_q        <= selPend_q;
        divAct_q        <= divPend_q;
        trimAct_q       <= trimPend_q;
        if (!(wrRef && writedata[`REF_SWITCH_BIT]))
          dividerSwitch_q <= 1'b0;
      end
      else if (dividerSwitch_q && (atBoundary || !runGen) && !wrRef && !wrTrim)
      begin
        selAct_q        <= selPend_q;
        divAct_q        <= divPend_q;
        trimAct_q       <= trimPend_q;
        dividerSwitch_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fractional divider: toggles on source edges every div+trim/512.
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      srcPrev_q      <= 1'b0;
      phaseCount_q   <= {(DIV_W+TRIM_W+1){1'b0}};
      trimAcc_q      <= 1'b0;
      fracAcc_q      <= {TRIM_W{1'b0}};
      refClk_q       <= 1'b0;
      refClockOutPin <= 1'b0;
      refClockOutEn  <= 1'b0;
    end
    else
    begin
      srcPrev_q <= srcLevel;
      if (!runGen)
      begin
        phaseCount_q <= {(DIV_W+TRIM_W+1){1'b0}};
        refClk_q     <= 1'b0;
      end
      else if (divAct_q == {DIV_W{1'b0}})
        refClk_q <= srcLevel;
      else if (srcEdge)
      begin
        if (halfDone)
        begin
          phaseCount_q <= {(DIV_W+TRIM_W+1){1'b0}};
          refClk_q     <= ~refClk_q;
          if (refClk_q)
          begin
            fracAcc_q <= fracSum[TRIM_W-1:0];
            trimAcc_q <= 1'b1;
          end
        end
        else
          phaseCount_q <= phaseCount_q + {{DIV_W{1'b0}}, 1'b1, {TRIM_W{1'b0}}};
      end
      refClockOutPin <= refClk_q & outEnable_q;
      refClockOutEn  <= outEnable_q & runGen;
    end
  end
endmodule
`default_nettype wire

// ---- bench/refclk_monitor.sv ----
// Purpose: Port assertions for the clock-control block.
// Assumes: An access is acknowledged in the cycle waitrequest is low.
// Notes:   Bound to every instance of the block.
`timescale 1ns/100ps
`default_nettype none
module refclk_monitor
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        refClockOutPin,
  input wire logic        refClockOutEn,
  input wire logic        usbRcSourceSelect,
  input wire logic        secondaryOscEnable,
  input wire logic [5:0]  rcTuneValue
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic rdAck;
  logic tuneAck;
  logic oscAck;
  assign rdAck = read && !waitrequest;
  assign tuneAck = write && !waitrequest && address == 4'h4;
  assign oscAck = write && !waitrequest && address == 4'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_oe_gates_pin: assert property (!refClockOutEn [*2] |-> !refClockOutPin)
    else $error("Reference pin high while not enabled.");
  a_tune_on_ack: assert property ($changed(rcTuneValue) |-> tuneAck || $past(tuneAck))
    else $error("Tuning changed without a write.");
  a_osc_on_ack: assert property ($changed({usbRcSourceSelect, secondaryOscEnable}) |->
    oscAck || $past(oscAck))
    else $error("Oscillator bits changed without a write.");
  a_tune_high_zero: assert property (rdAck && address == 4'h4 |-> readdata[31:6] == 26'h0)
    else $error("Tuning upper bits not zero.");
  a_tune_readback: assert property (rdAck && address == 4'h4 |-> readdata[5:0] == rcTuneValue)
    else $error("Tuning read differs from output.");
  a_ref_unused_zero: assert property (rdAck && address == 4'h8 |-> readdata[31] == 1'b0 &&
    readdata[14] == 1'b0 && readdata[10] == 1'b0 && readdata[7:4] == 4'h0)
    else $error("Reference control unused bits not zero.");
  a_trim_low_zero: assert property (rdAck && address == 4'hc |-> readdata[22:0] == 23'h0)
    else $error("Trim low bits not zero.");
  a_osc_readback: assert property (rdAck && address == 4'h0 |->
    readdata[2:1] == {usbRcSourceSelect, secondaryOscEnable})
    else $error("Oscillator bits read differ from outputs.");
endmodule
bind reference_clock_and_osc_tune refclk_monitor u_mon (.clk(clk), .rst(rst),
  .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .refClockOutPin(refClockOutPin), .refClockOutEn(refClockOutEn),
  .usbRcSourceSelect(usbRcSourceSelect), .secondaryOscEnable(secondaryOscEnable),
  .rcTuneValue(rcTuneValue));
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: Register and output checks of the clock-control block.
// Assumes: The slave acknowledges each access with one low cycle of waitrequest.
// Notes:   All sources toggle every cycle.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic        failSafeMonitor = 1'b0;
  logic        idleMode = 1'b0;
  logic        sleepMode = 1'b0;
  logic [8:0]  sourceClocks = 9'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        refClockOutPin;
  logic        refClockOutEn;
  logic        usbRcSourceSelect;
  logic        secondaryOscEnable;
  logic [2:0]  activeSource;
  logic [5:0]  rcTuneValue;
  logic [31:0] rdata;
  logic [31:0] tuneTab [3] = '{32'hffffffe0, 32'h0, 32'h1f};
  int          numErrors = 0;
  int          comparisons = 0;
  int          i;
  always #2 clk = ~clk;
  always @(posedge clk) sourceClocks <= ~sourceClocks;
  reference_clock_and_osc_tune u_dut (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .failSafeMonitor(failSafeMonitor), .idleMode(idleMode), .sleepMode(sleepMode),
    .sourceClocks(sourceClocks), .refClockOutPin(refClockOutPin),
    .refClockOutEn(refClockOutEn), .usbRcSourceSelect(usbRcSourceSelect),
    .secondaryOscEnable(secondaryOscEnable), .activeSource(activeSource),
    .rcTuneValue(rcTuneValue));
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      numErrors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= rd;
    write <= !rd;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    rdata = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0)
    begin
      numErrors++;
      test_done();
    end
  endtask
  task automatic unl(input logic [3:0] a, input logic [31:0] d);
    bus(0, 4'h0, 32'haa996655);
    bus(0, 4'h0, 32'h556699aa);
    bus(0, a, d);
  endtask
  task automatic tog(input logic e);
    int edges;
    logic p;
    edges = 0;
    repeat (4) @(posedge clk);
    p = refClockOutPin;
    repeat (64)
    begin
      @(posedge clk);
      if (refClockOutPin !== p)
        edges++;
      p = refClockOutPin;
    end
    chk({31'h0, edges > 0}, {31'h0, e});
  endtask
  task automatic poll(input logic [3:0] a, input int b);
    i = 0;
    do
    begin
      bus(1, a, 32'h0);
      i++;
    end
    while (rdata[b] !== 1'b0 && i < 40);
    chk({31'h0, rdata[b]}, 32'h0);
    if (i >= 40)
      test_done();
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(1, 4'h4, 32'h0);
    chk(rdata, 32'h0);
    bus(1, 4'h8, 32'h0);
    chk(rdata, 32'h0);
    bus(1, 4'hc, 32'h0);
    chk(rdata, 32'h0);
    bus(1, 4'h0, 32'h0);
    chk(rdata & 32'hf, 32'h0);
    bus(0, 4'h4, 32'h3f);
    bus(1, 4'h4, 32'h0);
    chk(rdata, 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      unl(4'h4, tuneTab[k]);
      bus(1, 4'h4, 32'h0);
      chk(rdata, tuneTab[k] & 32'h3f);
      chk({26'h0, rcTuneValue}, tuneTab[k] & 32'h3f);
    end
    unl(4'h0, 32'h6);
    @(posedge clk);
    chk({30'h0, usbRcSourceSelect, secondaryOscEnable}, 32'h3);
    unl(4'h0, 32'h505);
    poll(4'h0, 0);
    chk({29'h0, activeSource}, 32'h5);
    chk({30'h0, usbRcSourceSelect, secondaryOscEnable}, 32'h2);
    failSafeMonitor <= 1'b1;
    @(posedge clk);
    failSafeMonitor <= 1'b0;
    bus(1, 4'h0, 32'h0);
    chk(rdata & 32'h8, 32'h8);
    bus(0, 4'h8, 32'h80020003);
    bus(1, 4'h8, 32'h0);
    chk(rdata, 32'h00020003);
    bus(0, 4'hc, 32'hffffffff);
    bus(1, 4'hc, 32'h0);
    chk(rdata, 32'hff800000);
    bus(0, 4'h8, 32'h00029003);
    tog(1);
    chk({31'h0, refClockOutEn}, 32'h1);
    bus(0, 4'h8, 32'h00059203);
    poll(4'h8, 9);
    tog(1);
    bus(0, 4'h8, 32'h00058003);
    tog(0);
    bus(0, 4'h8, 32'h0005b003);
    idleMode <= 1'b1;
    tog(0);
    bus(0, 4'h8, 32'h00059003);
    tog(1);
    idleMode <= 1'b0;
    sleepMode <= 1'b1;
    tog(0);
    bus(0, 4'h8, 32'h00059803);
    tog(1);
    sleepMode <= 1'b0;
    bus(0, 4'h8, 32'h00051003);
    tog(0);
    test_done();
  end
endmodule
`default_nettype wire
